/* core/mted_detect.sv */
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/100ps
module mted_detect (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        sample_valid,
   input  wire logic [11:0] raw_x,
   input  wire logic [11:0] raw_y,
   input  wire logic [11:0] raw_z,
   input  wire logic [11:0] hpf_x,
   input  wire logic [11:0] hpf_y,
   input  wire logic [11:0] hpf_z,
   output logic             motion_event,
   output logic             transient_irq
);

   mted_pkg::mted_state_type st_q;
   mted_pkg::mted_state_type st_d;

   logic [2:0][11:0] raw_axis;
   logic [2:0][11:0] hpf_axis;
   logic [2:0][11:0] raw_mag;
   logic [2:0][11:0] tr_mag;
   logic [2:0]       tr_sign;
   logic [2:0]       motion_high;
   logic [2:0]       tr_hit;
   logic [6:0]       motion_thr_eff;
   logic [6:0]       tr_thr_eff;
   logic [11:0]      motion_thr_scaled;
   logic [11:0]      tr_thr_scaled;
   logic             bypass;
   logic             latch_en;
   logic [2:0]       axis_en;

   assign raw_axis = {raw_z, raw_y, raw_x};
   assign hpf_axis = {hpf_z, hpf_y, hpf_x};
   assign bypass   = st_q.transient_config[mted_pkg::HIGHPASS_BYPASS];
   assign latch_en = st_q.transient_config[mted_pkg::EVENT_LATCH_BIT];
   assign axis_en  = st_q.transient_config[mted_pkg::AXIS_EN_LSB +: 3];

   // Samples arrive on a fixed 8 g scale, 1/256 g per count, so one
   // threshold step equals sixteen sample counts at every full scale.
   assign motion_thr_eff = (st_q.low_noise &&
                            st_q.motion_threshold[6:0] > mted_pkg::LOW_NOISE_THR_CAP) ?
                           mted_pkg::LOW_NOISE_THR_CAP :
                           st_q.motion_threshold[6:0]; // [R1] [R2] [R3]
   assign tr_thr_eff = (st_q.low_noise &&
                        st_q.transient_threshold[6:0] > mted_pkg::LOW_NOISE_THR_CAP) ?
                       mted_pkg::LOW_NOISE_THR_CAP :
                       st_q.transient_threshold[6:0]; // [R3]
   assign motion_thr_scaled = {1'b0, motion_thr_eff, 4'h0}; // [R1] [R2]
   assign tr_thr_scaled     = {1'b0, tr_thr_eff, 4'h0};

   for (genvar i = 0; i < 3; i++) begin : g_axis
      logic [11:0] tr_data;
      assign tr_data        = bypass ? raw_axis[i] : hpf_axis[i]; // [R10]
      assign raw_mag[i]     = raw_axis[i][11] ? 12'(-raw_axis[i]) : raw_axis[i];
      assign tr_mag[i]      = tr_data[11] ? 12'(-tr_data) : tr_data;
      assign tr_sign[i]     = tr_data[11]; // [R17]
      assign motion_high[i] = raw_mag[i] > motion_thr_scaled;
      assign tr_hit[i]      = axis_en[i] && (tr_mag[i] > tr_thr_scaled); // [R12] [R20]
   end

   always_comb begin
      logic       acc_read;
      logic       acc_write;
      logic       src_clear;
      logic       cond;
      logic [7:0] cnt;
      logic [2:0] evt;
      logic [2:0] pol;
      acc_read  = 1'b0;
      acc_write = 1'b0;
      src_clear = 1'b0;
      cond      = 1'b0;
      cnt       = 8'h00;
      evt       = 3'h0;
      pol       = 3'h0;
      st_d      = st_q;

      // Every access sees one cycle of waitrequest; read data is
      // captured at the first edge and writes land at the second.
      acc_read  = avs_read && st_q.wait_req;
      acc_write = avs_write && !st_q.wait_req;
      st_d.wait_req = !(st_q.wait_req && (avs_read || avs_write));

      if (acc_read) begin
         case (avs_address[7:2])
            mted_pkg::IDX_MOTION_MODE:      st_d.rdata = {7'h00, st_q.motion_sel};
            mted_pkg::IDX_MOTION_THRESHOLD: st_d.rdata = st_q.motion_threshold;
            mted_pkg::IDX_DEBOUNCE_LIMIT:   st_d.rdata = st_q.debounce_limit; // [R6]
            mted_pkg::IDX_TRANSIENT_CONFIG: st_d.rdata = st_q.transient_config; // [R11]
            mted_pkg::IDX_TRANSIENT_SOURCE: begin
               st_d.rdata = {1'b0, st_q.event_active,
                             st_q.axis_event[2], st_q.axis_pol[2],
                             st_q.axis_event[1], st_q.axis_pol[1],
                             st_q.axis_event[0], st_q.axis_pol[0]}; // [R17]
               src_clear = 1'b1; // [R13] [R14] [R16]
            end
            mted_pkg::IDX_TRANSIENT_THRESH: st_d.rdata = st_q.transient_threshold;
            mted_pkg::IDX_SYSTEM_CONTROL:   st_d.rdata = {7'h00, st_q.low_noise};
            default:                        st_d.rdata = 8'h00;
         endcase
      end

      if (acc_write && avs_byteenable[0]) begin
         case (avs_address[7:2])
            mted_pkg::IDX_MOTION_MODE:
               st_d.motion_sel = avs_writedata[mted_pkg::MOTION_SEL_BIT];
            mted_pkg::IDX_MOTION_THRESHOLD:
               st_d.motion_threshold = avs_writedata[7:0];
            mted_pkg::IDX_DEBOUNCE_LIMIT:
               st_d.debounce_limit = avs_writedata[7:0]; // [R6]
            mted_pkg::IDX_TRANSIENT_CONFIG:
               st_d.transient_config = {3'h0, avs_writedata[4:0]}; // [R11]
            mted_pkg::IDX_TRANSIENT_THRESH:
               st_d.transient_threshold = avs_writedata[7:0];
            mted_pkg::IDX_SYSTEM_CONTROL:
               st_d.low_noise = avs_writedata[mted_pkg::LOW_NOISE_BIT];
            default: ;
         endcase
      end

      // Freefall needs every axis at or below threshold, motion any above.
      cond = st_q.motion_sel ? (|motion_high) : ~(|motion_high); // [R19]
      cnt  = st_q.debounce_cnt;
      if (cnt > st_q.debounce_limit) begin
         cnt = st_q.debounce_limit; // [R8]
      end
      if (sample_valid) begin // [R9]
         if (cond) begin
            if (cnt < st_q.debounce_limit) begin
               cnt = cnt + 8'h01; // [R21] [R8]
            end
         end else if (st_q.motion_threshold[mted_pkg::DEBOUNCE_MODE_BIT]) begin
            cnt = 8'h00; // [R4]
         end else if (cnt != 8'h00) begin
            cnt = cnt - 8'h01; // [R5]
         end
         st_d.motion_event = cond && (cnt == st_q.debounce_limit); // [R7]
      end
      st_d.debounce_cnt = cnt;

      // A read clears first, so a sample in the same cycle still lands.
      evt = src_clear ? 3'h0 : st_q.axis_event;
      pol = src_clear ? 3'h0 : st_q.axis_pol;
      if (sample_valid) begin
         if (!latch_en || !(st_q.event_active && !src_clear)) begin
            evt = tr_hit; // [R22]
            pol = tr_hit & tr_sign;
         end else begin
            // Latched and active: event flags set only, none drops before a read; a hit axis takes its new sign.
            evt = evt | tr_hit; // [R15] [R16] [R13]
            pol = (pol & ~tr_hit) | (tr_hit & tr_sign); // [R15]
         end
      end
      st_d.axis_event    = evt;
      st_d.axis_pol      = pol;
      st_d.event_active  = |evt; // [R18]
      st_d.transient_irq = |evt; // [R20] [R14]
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st_q.wait_req            <= 1'b1;
         st_q.rdata               <= mted_pkg::RESET_BYTE;
         st_q.motion_sel          <= 1'b0;
         st_q.motion_threshold    <= mted_pkg::RESET_BYTE;
         st_q.debounce_limit      <= mted_pkg::RESET_BYTE; // [R6]
         st_q.transient_config    <= mted_pkg::RESET_BYTE; // [R11]
         st_q.transient_threshold <= mted_pkg::RESET_BYTE;
         st_q.low_noise           <= 1'b0;
         st_q.debounce_cnt        <= 8'h00;
         st_q.motion_event        <= 1'b0;
         st_q.axis_event          <= 3'h0;
         st_q.axis_pol            <= 3'h0;
         st_q.event_active        <= 1'b0; // [R18]
         st_q.transient_irq       <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   assign avs_readdata    = {24'h000000, st_q.rdata};
   assign avs_waitrequest = st_q.wait_req;
   assign motion_event    = st_q.motion_event;
   assign transient_irq   = st_q.transient_irq;

endmodule

/* core/mted_pkg.sv */
// What this block does
// R1: Threshold field is unsigned 0..127, 0.063 g steps.
// R2: Thresholds reach 8 g at any full scale.
// R3: Low-noise mode caps threshold at 4 g.
// R4: Mode one clears counter on false sample.
// R5: Mode zero decrements counter, stopping at zero.
// R6: Eight-bit read/write debounce limit, resets zero.
// R7: Motion flag set when counter equals limit.
// R8: Counter saturates at the programmed limit.
// R9: Counter steps once per output sample.
// R10: Bypass bit selects raw or filtered data.
// R11: Config holds latch and axis enables.
// R12: Enabled axis flags when delta exceeds threshold.
// R13: Latched flags held until source is read.
// R14: Source read drops the transient request.
// R15: While latched and active, flags may set, never clear.
// R16: Latched active only adds flags; read clears all.
// R17: Source layout: active, then Z/Y/X pairs.
// R18: Active bit is OR of axis flags.
// R19: Freefall all axes low, motion any high.
// R20: Transient flags magnitude over threshold, raises request.
// R21: Counter rises on each matching sample.
// R22: Unlatched status follows detection every sample.
package mted_pkg;

   // Register indices; the byte address is four times the index.
   localparam logic [5:0] IDX_MOTION_MODE      = 6'h15;
   localparam logic [5:0] IDX_MOTION_THRESHOLD = 6'h17;
   localparam logic [5:0] IDX_DEBOUNCE_LIMIT   = 6'h18;
   localparam logic [5:0] IDX_TRANSIENT_CONFIG = 6'h1d;
   localparam logic [5:0] IDX_TRANSIENT_SOURCE = 6'h1e;
   localparam logic [5:0] IDX_TRANSIENT_THRESH = 6'h1f;
   localparam logic [5:0] IDX_SYSTEM_CONTROL   = 6'h2a;

   // Field positions.
   localparam int DEBOUNCE_MODE_BIT  = 7;
   localparam int MOTION_SEL_BIT     = 0;
   localparam int LOW_NOISE_BIT      = 0;
   localparam int HIGHPASS_BYPASS    = 0;
   localparam int AXIS_EN_LSB        = 1;
   localparam int EVENT_LATCH_BIT    = 4;

   // Reset values.
   localparam logic [7:0] RESET_BYTE = 8'h00;

   // Threshold cap in low-noise mode: 64 steps of 1/16 g is 4 g.
   localparam logic [6:0] LOW_NOISE_THR_CAP = 7'h40;

   typedef struct packed {
      logic       wait_req;
      logic [7:0] rdata;
      logic       motion_sel;
      logic [7:0] motion_threshold;
      logic [7:0] debounce_limit;
      logic [7:0] transient_config;
      logic [7:0] transient_threshold;
      logic       low_noise;
      logic [7:0] debounce_cnt;
      logic       motion_event;
      logic [2:0] axis_event;
      logic [2:0] axis_pol;
      logic       event_active;
      logic       transient_irq;
   } mted_state_type;

endpackage

/* dv/mted_detect_chk.sv */
`timescale 1ns/100ps
module mted_detect_chk (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        sample_valid,
   input wire logic        motion_event,
   input wire logic        transient_irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   logic src_rd;
   assign src_rd = avs_read && avs_waitrequest
                   && avs_address[7:2] == mted_pkg::IDX_TRANSIENT_SOURCE;
   wait_ans_a: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
   wait_one_a: assert property (
      !avs_waitrequest |=> avs_waitrequest) else $error("long answer");
   wait_idle_a: assert property (
      !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest) else $error("idle answer");
   motion_hold_a: assert property (
      !sample_valid |=> $stable(motion_event)) else $error("motion moved");
   irq_rise_a: assert property (
      $rose(transient_irq) |-> $past(sample_valid)) else $error("irq rose");
   irq_fall_a: assert property (
      $fell(transient_irq) |-> $past(sample_valid) || $past(src_rd)) else $error("irq fell");
   src_clr_a: assert property (
      src_rd && !sample_valid |=> !transient_irq) else $error("irq kept");
   src_top_a: assert property (
      src_rd |=> avs_readdata[7:6] == {1'b0, $past(transient_irq)}) else $error("src top");
   cover property ($rose(motion_event));
   cover property (src_rd && transient_irq);
   cover property ($fell(transient_irq) && !$past(src_rd));
endmodule
bind mted_detect mted_detect_chk i_chk (.*);

/* dv/mted_host.sv */
`timescale 1ns/100ps
module mted_host (
   input  wire logic        core_clk,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest,
   output logic [7:0]       avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic [31:0]      avs_writedata,
   output logic [3:0]       avs_byteenable
);
   initial {avs_address, avs_read, avs_write, avs_writedata} = '0;
   assign avs_byteenable = 4'h1;
   // Holds the request until waitrequest is seen low at a rising edge.
   task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(posedge core_clk);
      avs_address   <= a;
      avs_writedata <= {24'h000000, d};
      avs_write     <= w;
      avs_read      <= !w;
      do @(posedge core_clk); while (avs_waitrequest);
      q = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask
endmodule

/* dv/test_motion_transient_event_detect.sv */
`timescale 1ns/100ps
module test_motion_transient_event_detect;
   logic        core_clk = 1'b0, reset = 1'b1, sample_valid = 1'b0;
   logic [11:0] raw_x = '0, raw_y = '0, raw_z = '0, hpf_x = '0, hpf_y = '0, hpf_z = '0;
   logic [7:0]  avs_address, rv;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0]  avs_byteenable;
   logic        avs_read, avs_write, avs_waitrequest, motion_event, transient_irq;
   int          bad_count = 0, checks = 0;
   always #2 core_clk = ~core_clk;
   mted_detect i_mted_detect (.*);
   mted_host i_mted_host (.*);
   task chk(input string n, input logic [7:0] s, e);
      checks++;
      if (s !== e) begin
         $display("[FAIL] %s exp %h seen %h", n, e, s);
         bad_count++;
      end
   endtask
   task wr(input logic [7:0] a, d); i_mted_host.acc(1'b1, a, d, rv); endtask
   task rd(input logic [7:0] a); i_mted_host.acc(1'b0, a, 8'h00, rv); endtask
   // One output sample on X and Z, raw or high-pass, then settle.
   task smp(input logic [11:0] x, z, input logic r);
      @(posedge core_clk);
      sample_valid <= 1'b1;
      raw_x <= r ? x : 12'h000;
      raw_z <= r ? z : 12'h000;
      hpf_x <= r ? 12'h000 : x;
      hpf_z <= r ? 12'h000 : z;
      @(posedge core_clk);
      sample_valid <= 1'b0;
      @(posedge core_clk);
   endtask
   task mot(input logic [5:0] p, input int n);
      for (int i = 0; i < n; i++) smp(p[i] ? 12'h020 : 12'h000, 12'h000, 1'b1);
   endtask
   task t_regs;
      rd(8'h60); chk("limit rst", rv, 8'h00);
      wr(8'h60, 8'ha5); rd(8'h60); chk("limit rw", rv, 8'ha5);
      wr(8'h74, 8'hff); rd(8'h74); chk("cfg", rv, 8'h1f);
      rd(8'h40); chk("unmapped", rv, 8'h00);
   endtask
   task t_debounce;
      wr(8'h54, 8'h01); wr(8'h60, 8'h03); wr(8'h5c, 8'h81);
      mot(6'h1b, 5); chk("clear mode", motion_event, 8'h00);
      mot(6'h01, 1); chk("limit hit", motion_event, 8'h01);
      wr(8'h5c, 8'h01);
      mot(6'h03, 3); chk("saturate", motion_event, 8'h00);
      mot(6'h01, 1); chk("decrement", motion_event, 8'h01);
   endtask
   task t_scale;
      wr(8'h60, 8'h00); wr(8'h5c, 8'h7f); wr(8'h54, 8'h00);
      smp(12'h000, 12'h000, 1'b1); chk("freefall", motion_event, 8'h01);
      smp(12'h7ff, 12'h000, 1'b1); chk("no freefall", motion_event, 8'h00);
      wr(8'h54, 8'h01);
      smp(12'h500, 12'h000, 1'b1); chk("full thr", motion_event, 8'h00);
      smp(12'h7ff, 12'h000, 1'b1); chk("8g", motion_event, 8'h01);
      wr(8'ha8, 8'h01);
      smp(12'h500, 12'h000, 1'b1); chk("low noise", motion_event, 8'h01);
      wr(8'ha8, 8'h00);
   endtask
   task t_trans;
      wr(8'h74, 8'h1a); wr(8'h7c, 8'h01); rd(8'h78);
      smp(12'hfe0, 12'h000, 1'b0);
      smp(12'h000, 12'h020, 1'b0);
      smp(12'h000, 12'h000, 1'b0); chk("latched", transient_irq, 8'h01);
      rd(8'h78); chk("src", rv, 8'h63);
      chk("irq clr", transient_irq, 8'h00);
      rd(8'h78); chk("src clr", rv, 8'h00);
      wr(8'h74, 8'h13);
      smp(12'h020, 12'h000, 1'b0); chk("bypass hpf", transient_irq, 8'h00);
      smp(12'h020, 12'h000, 1'b1); rd(8'h78); chk("bypass raw", rv, 8'h42);
      wr(8'h74, 8'h02);
      smp(12'h000, 12'h020, 1'b0); chk("z off", transient_irq, 8'h00);
      smp(12'h020, 12'h000, 1'b0); chk("follow", transient_irq, 8'h01);
      smp(12'h000, 12'h000, 1'b0); chk("drop", transient_irq, 8'h00);
   endtask
   task end_of_test;
      if (bad_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      t_regs;
      t_debounce;
      t_scale;
      t_trans;
      end_of_test;
   end
   initial begin
      #20000;
      bad_count++;
      end_of_test;
   end
endmodule
